// ==== hdl/temp_readout_pkg.sv ====
// shared constants for the temperature readout and fan code block
`default_nettype none
package temp_readout_pkg;
    localparam int TEMP_W = 8;
    localparam int FAN_W = 8;
    localparam int AVG_COUNT = 16;
    localparam int AVG_SHIFT = 4;
    localparam int ACC_W = TEMP_W + AVG_SHIFT;
    localparam int CFG_W = 8;
    localparam int CFG_REMOTE2_BIT = 7;
    localparam logic [TEMP_W-1:0] TEMP_RESET = 8'h00;
    localparam logic [FAN_W-1:0] FAN_RESET = 8'h00;
    localparam logic [FAN_W-1:0] FAN_FULL = 8'hff;
    localparam int CLK_HZ = 100_000_000;
    // remote measurement time in microseconds, 9.6 ms
    localparam int REMOTE_MEAS_US = 9600;
    localparam int REMOTE_MEAS_CYC = (CLK_HZ / 1_000_000) * REMOTE_MEAS_US;
    localparam int SAMPLE_CYC = REMOTE_MEAS_CYC / AVG_COUNT;
    typedef enum logic [1:0] {
        CH_LOCAL = 2'b00,
        CH_REMOTE1 = 2'b01,
        CH_REMOTE2 = 2'b10
    } channel_t;
endpackage
`default_nettype wire

// ==== hdl/temp_averager.sv ====
// sixteen-sample averager for one remote channel
`default_nettype none
module temp_averager
    import temp_readout_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // sample in
    input wire logic sample_valid,
    input wire logic [TEMP_W-1:0] sample,
    input wire logic flush,
    // averaged result
    output logic result_valid,
    output logic [TEMP_W-1:0] result
);
    logic signed [ACC_W-1:0] acc_r;
    logic [AVG_SHIFT-1:0] cnt_r;
    logic signed [ACC_W-1:0] sum;
    logic valid_r;
    logic [TEMP_W-1:0] result_r;

    assign sum = acc_r + ACC_W'(signed'(sample));
    assign result_valid = valid_r;
    assign result = result_r;

    always_ff @(posedge clk) begin
        if (!rst_n || flush) begin
            acc_r <= '0;
            cnt_r <= '0;
        end else if (sample_valid) begin
            // count wraps after sixteen, acc restarts
            cnt_r <= cnt_r + 1'b1;
            acc_r <= (cnt_r == AVG_SHIFT'(AVG_COUNT - 1)) ? '0 : sum;
        end
    end

    // arithmetic shift keeps twos complement sign
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            valid_r <= 1'b0;
            result_r <= TEMP_RESET;
        end else begin
            valid_r <= sample_valid && !flush && cnt_r == AVG_SHIFT'(AVG_COUNT - 1);
            if (sample_valid && !flush && cnt_r == AVG_SHIFT'(AVG_COUNT - 1)) begin
                result_r <= sum[ACC_W-1:AVG_SHIFT]; // RL4
            end
        end
    end
endmodule
`default_nettype wire

// ==== hdl/temp_readout_fan_dac_code.sv ====
// temperature result registers, remote averaging and fan speed code
`default_nettype none
// Notes on behaviour
// RL1: every temperature result is an 8-bit twos complement value.
// RL2: one degree per bit; zero is all zeros, minus one all ones.
// RL3: config bit 7 low gives overtemp and general input; high gives second diode.
// RL4: each remote result is the average of sixteen conversions.
// RL5: a full remote measurement with averaging takes nominally 9.6 ms.
// RL6: unsigned 8-bit fan code drives the DAC, zero is minimum speed.
// RL7: power-on reset loads fan code with zero.
// RL8: fan output pin high at power-up selects nand test mode.
// RL9: each completed result is stored in that sensor's value register.
// RL10: active overtemp forces fan output to ff, programmed code kept.
// RL11: remote value registers change only when an averaged result completes.
module temp_readout_fan_dac_code
    import temp_readout_pkg::*;
#(
    parameter int MEAS_CYCLES = REMOTE_MEAS_CYC
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // converter samples, one per conversion
    input wire logic adc_valid,
    input wire temp_readout_pkg::channel_t adc_channel,
    input wire logic [TEMP_W-1:0] adc_sample,
    // register access
    input wire logic [CFG_W-1:0] config_wr_data,
    input wire logic config_wr,
    input wire logic [FAN_W-1:0] fan_code_wr_data,
    input wire logic fan_code_wr,
    // pins
    input wire logic overtemp_in_n,
    input wire logic general_input,
    input wire logic nand_test_input,
    // control and readback
    output logic [CFG_W-1:0] config_r,
    output logic [FAN_W-1:0] fan_speed_code,
    output logic [TEMP_W-1:0] local_temp,
    output logic [TEMP_W-1:0] remote1_temp,
    output logic [TEMP_W-1:0] remote2_temp,
    output logic remote2_enabled,
    output logic general_input_level,
    output logic overtemp_active,
    output logic conv_start,
    output logic [1:0] conv_channel,
    // dac and test mode
    output logic [FAN_W-1:0] fan_speed_output,
    output logic nand_test_mode
);
    localparam int SAMPLE_CYCLES = MEAS_CYCLES / AVG_COUNT;
    localparam int TMR_W = $clog2(SAMPLE_CYCLES + 1);

    // a slot must hold the whole back-to-back round of conversions
    if (SAMPLE_CYCLES <= int'(CH_REMOTE2)) begin : g_slot_check
        $error("MEAS_CYCLES too small for one conversion round per slot");
    end

    logic [FAN_W-1:0] fan_code_r;
    logic [FAN_W-1:0] fan_out_r;
    logic [TEMP_W-1:0] local_r;
    logic [TEMP_W-1:0] remote1_r;
    logic [TEMP_W-1:0] remote2_r;
    logic [CFG_W-1:0] cfg_r;
    logic ot_s1_r, ot_s2_r, gi_s1_r, gi_s2_r, nt_s1_r, nt_s2_r;
    logic strap_done_r, test_r;
    logic [1:0] strap_wait_r;
    logic [TMR_W-1:0] tmr_r;
    logic start_r;
    logic [1:0] ch_r;
    logic r1_valid, r2_valid;
    logic [TEMP_W-1:0] r1_avg, r2_avg;
    logic remote2_on;

    assign remote2_on = cfg_r[CFG_REMOTE2_BIT]; // RL3

    // pin synchronisers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ot_s1_r <= 1'b1;
            ot_s2_r <= 1'b1;
            gi_s1_r <= 1'b0;
            gi_s2_r <= 1'b0;
            nt_s1_r <= 1'b0;
            nt_s2_r <= 1'b0;
        end else begin
            ot_s1_r <= overtemp_in_n;
            ot_s2_r <= ot_s1_r;
            gi_s1_r <= general_input;
            gi_s2_r <= gi_s1_r;
            nt_s1_r <= nand_test_input;
            nt_s2_r <= nt_s1_r;
        end
    end

    // strap waits until the second sync stage holds a post-reset sample
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            strap_wait_r <= '0;
        end else begin
            strap_wait_r <= {strap_wait_r[0], 1'b1};
        end
    end

    // strap caught once; later pin changes are ignored
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            strap_done_r <= 1'b0;
            test_r <= 1'b0;
        end else if (!strap_done_r && strap_wait_r[1]) begin
            strap_done_r <= 1'b1;
            test_r <= nt_s2_r; // RL8
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cfg_r <= '0;
        end else if (config_wr) begin
            cfg_r <= config_wr_data;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            fan_code_r <= FAN_RESET; // RL7
        end else if (fan_code_wr) begin
            fan_code_r <= fan_code_wr_data; // RL6
        end
    end

    // override never touches fan_code_r, so the code survives it
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            fan_out_r <= FAN_RESET;
        end else if (!ot_s2_r && !remote2_on) begin
            fan_out_r <= FAN_FULL; // RL10
        end else begin
            fan_out_r <= fan_code_r;
        end
    end

    // one round of conversions per slot, so sixteen slots make one remote measurement
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            tmr_r <= '0;
            start_r <= 1'b0;
            ch_r <= CH_LOCAL;
        end else begin
            start_r <= 1'b0;
            if (tmr_r == TMR_W'(SAMPLE_CYCLES - 1)) begin
                tmr_r <= '0;
                // no conversions until the strap is known
                start_r <= strap_done_r && !test_r;
                ch_r <= CH_LOCAL;
            end else begin
                tmr_r <= tmr_r + 1'b1; // RL5
                if (start_r) begin
                    case (ch_r)
                        CH_LOCAL: begin
                            start_r <= 1'b1;
                            ch_r <= CH_REMOTE1;
                        end
                        CH_REMOTE1: begin
                            start_r <= remote2_on;
                            ch_r <= remote2_on ? CH_REMOTE2 : CH_REMOTE1;
                        end
                        default: begin
                            ch_r <= ch_r;
                        end
                    endcase
                end
            end
        end
    end

    temp_averager u_avg1 (
        .clk(clk),
        .rst_n(rst_n),
        .sample_valid(adc_valid && adc_channel == CH_REMOTE1),
        .sample(adc_sample),
        .flush(1'b0),
        .result_valid(r1_valid),
        .result(r1_avg)
    );

    // a disabled second channel drops its partial average
    temp_averager u_avg2 (
        .clk(clk),
        .rst_n(rst_n),
        .sample_valid(adc_valid && adc_channel == CH_REMOTE2 && remote2_on),
        .sample(adc_sample),
        .flush(!remote2_on),
        .result_valid(r2_valid),
        .result(r2_avg)
    );

    // value registers load whole results only
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            local_r <= TEMP_RESET;
            remote1_r <= TEMP_RESET;
            remote2_r <= TEMP_RESET;
        end else begin
            if (adc_valid && adc_channel == CH_LOCAL) begin
                local_r <= adc_sample; // RL1 RL2 RL9
            end
            if (r1_valid) begin
                remote1_r <= r1_avg; // RL9 RL11
            end
            if (r2_valid) begin
                remote2_r <= r2_avg; // RL9 RL11
            end
        end
    end

    assign config_r = cfg_r;
    assign fan_speed_code = fan_code_r;
    assign local_temp = local_r;
    assign remote1_temp = remote1_r;
    assign remote2_temp = remote2_r;
    assign remote2_enabled = remote2_on;
    assign general_input_level = gi_s2_r && !remote2_on;
    assign overtemp_active = !ot_s2_r && !remote2_on;
    assign conv_start = start_r;
    assign conv_channel = ch_r;
    assign fan_speed_output = fan_out_r;
    assign nand_test_mode = test_r;
endmodule
`default_nettype wire

// ==== verif/temp_readout_checker.sv ====
// port assertions for the temperature readout block
`default_nettype none
module temp_readout_checker
    import temp_readout_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // watched ports
    input wire logic adc_valid,
    input wire channel_t adc_channel,
    input wire logic [TEMP_W-1:0] adc_sample,
    input wire logic [CFG_W-1:0] config_wr_data,
    input wire logic config_wr,
    input wire logic [FAN_W-1:0] fan_code_wr_data,
    input wire logic fan_code_wr,
    input wire logic [FAN_W-1:0] fan_speed_code,
    input wire logic [TEMP_W-1:0] local_temp,
    input wire logic [TEMP_W-1:0] remote1_temp,
    input wire logic remote2_enabled,
    input wire logic overtemp_active,
    input wire logic conv_start,
    input wire logic [FAN_W-1:0] fan_speed_output,
    input wire logic nand_test_mode
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    a_fan_load: assert property (fan_code_wr |=> fan_speed_code == $past(fan_code_wr_data)) else $error("fan load");
    a_fan_reset: assert property (disable iff (1'b0) !rst_n |=> fan_speed_code == FAN_RESET) else $error("fan rst");
    a_forced_full: assert property (overtemp_active [*2] |-> fan_speed_output == FAN_FULL) else $error("not full");
    a_code_passed: assert property (!overtemp_active [*2] |-> fan_speed_output == $past(fan_speed_code)) else $error("dac");
    a_cfg_enable: assert property (config_wr |=> remote2_enabled == $past(config_wr_data[CFG_REMOTE2_BIT]))
        else $error("cfg");
    a_pins_gated: assert property (remote2_enabled [*4] |-> !overtemp_active) else $error("not gated");
    a_local_store: assert property (adc_valid && adc_channel == CH_LOCAL |=> local_temp == $past(adc_sample))
        else $error("local");
    a_remote_atomic: assert property ($changed(remote1_temp) |-> $past(adc_valid && adc_channel == CH_REMOTE1, 2))
        else $error("partial");
    a_test_quiet: assert property (nand_test_mode |-> !conv_start) else $error("conv in test");
    c_forced: cover property (overtemp_active && fan_speed_code != FAN_FULL);
    c_remote: cover property ($changed(remote1_temp));
    c_second: cover property (remote2_enabled && adc_valid && adc_channel == CH_REMOTE2);
endmodule
bind temp_readout_fan_dac_code temp_readout_checker chk (
    .clk(clk),
    .rst_n(rst_n),
    .adc_valid(adc_valid),
    .adc_channel(adc_channel),
    .adc_sample(adc_sample),
    .config_wr_data(config_wr_data),
    .config_wr(config_wr),
    .fan_code_wr_data(fan_code_wr_data),
    .fan_code_wr(fan_code_wr),
    .fan_speed_code(fan_speed_code),
    .local_temp(local_temp),
    .remote1_temp(remote1_temp),
    .remote2_enabled(remote2_enabled),
    .overtemp_active(overtemp_active),
    .conv_start(conv_start),
    .fan_speed_output(fan_speed_output),
    .nand_test_mode(nand_test_mode)
);
`default_nettype wire

// ==== verif/diode_model.sv ====
// behavioural diode sensors and converter front end
`default_nettype none
module diode_model
    import temp_readout_pkg::*;
(
    // request
    input wire logic clk,
    input wire logic conv_start,
    input wire logic [1:0] conv_channel,
    input wire logic [7:0] temps [3],
    // sample out
    output logic adc_valid,
    output var channel_t adc_channel,
    output logic [7:0] adc_sample
);
    logic [2:0] odd_r = 3'h0;
    // remote readings dither one degree so the rounding of the average shows
    always_ff @(posedge clk) begin
        adc_valid <= conv_start;
        adc_channel <= channel_t'(conv_channel);
        adc_sample <= conv_start ? temps[conv_channel] - {7'h0, odd_r[conv_channel] & |conv_channel} : ~adc_sample;
        if (conv_start) odd_r[conv_channel] <= ~odd_r[conv_channel];
    end
endmodule
`default_nettype wire

// ==== verif/temp_readout_fan_dac_code_bench.sv ====
// self-checking bench for the temperature readout block
`default_nettype none
module temp_readout_fan_dac_code_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import temp_readout_pkg::*;
    logic clk = 0, rst_n = 0, config_wr = 0, fan_code_wr = 0, overtemp_in_n = 1, general_input = 1;
    logic nand_test_input = 0, adc_valid, remote2_enabled, general_input_level, overtemp_active, conv_start;
    logic nand_test_mode;
    channel_t adc_channel;
    logic [7:0] adc_sample, config_r, fan_speed_code, local_temp, remote1_temp, remote2_temp, fan_speed_output;
    logic [7:0] config_wr_data = 0, fan_code_wr_data = 0, temps [3] = '{8'h00, 8'h00, 8'h00};
    logic [1:0] conv_channel;
    int error_cnt = 0, samples_checked = 0;
    // short remote measurement so averaging shows in a few hundred cycles
    localparam int MEAS = 160;
    always #5 clk = ~clk;
    temp_readout_fan_dac_code #(.MEAS_CYCLES(MEAS)) DUT (
        .clk(clk),
        .rst_n(rst_n),
        .adc_valid(adc_valid),
        .adc_channel(adc_channel),
        .adc_sample(adc_sample),
        .config_wr_data(config_wr_data),
        .config_wr(config_wr),
        .fan_code_wr_data(fan_code_wr_data),
        .fan_code_wr(fan_code_wr),
        .overtemp_in_n(overtemp_in_n),
        .general_input(general_input),
        .nand_test_input(nand_test_input),
        .config_r(config_r),
        .fan_speed_code(fan_speed_code),
        .local_temp(local_temp),
        .remote1_temp(remote1_temp),
        .remote2_temp(remote2_temp),
        .remote2_enabled(remote2_enabled),
        .general_input_level(general_input_level),
        .overtemp_active(overtemp_active),
        .conv_start(conv_start),
        .conv_channel(conv_channel),
        .fan_speed_output(fan_speed_output),
        .nand_test_mode(nand_test_mode)
    );
    diode_model diodes (
        .clk(clk),
        .conv_start(conv_start),
        .conv_channel(conv_channel),
        .temps(temps),
        .adc_valid(adc_valid),
        .adc_channel(adc_channel),
        .adc_sample(adc_sample)
    );
    task automatic check(input logic [7:0] got, exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // waits under a bound, then compares
    task automatic settle(ref logic [7:0] sig, input logic [7:0] v);
        repeat (3000) if (sig !== v) @(negedge clk);
        check(sig, v);
    endtask
    task automatic wr(input bit cfg, input logic [7:0] v);
        @(negedge clk);
        config_wr_data = v;
        fan_code_wr_data = v;
        config_wr = cfg;
        fan_code_wr = !cfg;
        @(negedge clk);
        config_wr = 0;
        fan_code_wr = 0;
    endtask
    task automatic t_fan;
        check(fan_speed_code, 8'h00);
        wr(0, 8'h80);
        @(negedge clk);
        check(fan_speed_output, 8'h80);
        overtemp_in_n = 0;
        wr(0, 8'h40);
        repeat (4) @(negedge clk);
        check(fan_speed_output, FAN_FULL);
        check(fan_speed_code, 8'h40);
        overtemp_in_n = 1;
        repeat (6) @(negedge clk);
        check(fan_speed_output, 8'h40);
        check({7'h0, nand_test_mode}, 8'h00);
        $display("fan done");
    endtask
    task automatic t_temp;
        logic [7:0] tbl [4] = '{8'h80, 8'hff, 8'h01, 8'h7f};
        int n = 0;
        foreach (tbl[i]) begin
            temps[0] = tbl[i];
            settle(local_temp, tbl[i]);
        end
        temps[1] = 8'hce;
        settle(remote1_temp, 8'hcd);
        // one remote measurement span must hold exactly sixteen conversions of a channel
        repeat (MEAS) begin
            @(negedge clk);
            if (conv_start && conv_channel == CH_REMOTE1) begin
                n++;
            end
        end
        check(8'(n), 8'(AVG_COUNT));
        $display("temperature done");
    endtask
    task automatic t_second;
        temps[2] = 8'h32;
        general_input = 0;
        repeat (600) @(negedge clk);
        check(remote2_temp, 8'h00);
        check({7'h0, general_input_level}, 8'h00);
        general_input = 1;
        repeat (3) @(negedge clk);
        check({7'h0, general_input_level}, 8'h01);
        wr(1, 8'h80);
        overtemp_in_n = 0;
        settle(remote2_temp, 8'h31);
        check(config_r, 8'h80);
        check({6'h0, remote2_enabled, general_input_level}, 8'h02);
        check(fan_speed_output, 8'h40);
        check({7'h0, overtemp_active}, 8'h00);
        overtemp_in_n = 1;
        $display("second channel done");
    endtask
    task automatic t_test;
        int n = 0;
        nand_test_input = 1;
        rst_n = 0;
        repeat (6) @(negedge clk);
        rst_n = 1;
        repeat (5) @(negedge clk);
        check(fan_speed_code, 8'h00);
        check({7'h0, nand_test_mode}, 8'h01);
        // several slots long: no conversion may start in test mode
        repeat (4 * MEAS / AVG_COUNT) begin
            @(negedge clk);
            if (conv_start) begin
                n++;
            end
        end
        check(8'(n), 8'h00);
        $display("test mode done");
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial begin
        repeat (6) @(negedge clk);
        rst_n = 1;
        t_fan;
        t_temp;
        t_second;
        t_test;
        close_out;
    end
    // tests need about 1.3k cycles; settle bounds alone could reach far more
    initial begin
        #100us;
        error_cnt++;
        close_out;
    end
endmodule
`default_nettype wire
